// ### rtl/cscc_params.svh
// Offsets, field positions, reset values and write masks of the status/control bank.
`ifndef CSCC_PARAMS_SVH
`define CSCC_PARAMS_SVH

`define CSCC_ADDR_STATUS     8'h00
`define CSCC_ADDR_CONTROL    8'h04
`define CSCC_ADDR_EXCWORD    8'h08
`define CSCC_ADDR_SYSCTL     8'h0C
`define CSCC_ADDR_DECODE_W   8

`define CSCC_SR_CARRY        0
`define CSCC_SR_ZERO         1
`define CSCC_SR_WRAP         2
`define CSCC_SR_NEG          3
`define CSCC_SR_REPEAT       4
`define CSCC_SR_IPL_LO       5
`define CSCC_SR_HALF         8
`define CSCC_SR_LOOP         9
`define CSCC_SR_ANY_CLIP     10
`define CSCC_SR_ANY_OVF      11
`define CSCC_SR_SECOND_CLIP  12
`define CSCC_SR_FIRST_CLIP   13
`define CSCC_SR_SECOND_OVF   14
`define CSCC_SR_FIRST_OVF    15

`define CSCC_CC_INT_MODE     0
`define CSCC_CC_ROUND        1
`define CSCC_CC_FRAME        2
`define CSCC_CC_IPL_HI       3
`define CSCC_CC_CLIP_WIDTH   4
`define CSCC_CC_STORE_CLIP   5
`define CSCC_CC_SECOND_CLIP  6
`define CSCC_CC_FIRST_CLIP   7
`define CSCC_CC_DEPTH_LO     8
`define CSCC_CC_EXIT         11
`define CSCC_CC_SIGN_LO      12

`define CSCC_SR_RESET        16'h0000
`define CSCC_CC_RESET        16'h0020
`define CSCC_CC_WMASK        16'h30FB
`define CSCC_SR_RO_MASK      16'h0210
`define CSCC_SYS_NESTDIS     0
`define CSCC_USER_MAX_IPL    4'h7

`endif

// ### rtl/cscc_pkg.sv
// Types shared by the status/control bank.
package cscc_pkg;
    typedef enum logic [1:0] {
        CSCC_MUL_SIGNED   = 2'b00,
        CSCC_MUL_UNSIGNED = 2'b01,
        CSCC_MUL_MIXED    = 2'b10,
        CSCC_MUL_RESERVED = 2'b11
    } cscc_mul_e;

    typedef struct packed {
        logic [15:0] status_reg;
        logic [15:0] control_reg;
        logic [15:0] exc_word_reg;
        logic        nesting_disable_reg;
        logic        dphase_reg;
        logic        dwrite_reg;
        logic [7:0]  daddr_reg;
        logic [31:0] rdata_reg;
        logic        exit_pulse_reg;
    } cscc_state_s;
endpackage

// ### rtl/cscc_core.sv
// Processor status word and core control word behind an AHB-Lite slave.
`timescale 1ns/10ps
`default_nettype none
`include "cscc_params.svh"

module cscc_core
    import cscc_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        alu_update,
    input  wire logic        alu_neg,
    input  wire logic        alu_wrap,
    input  wire logic        alu_zero,
    input  wire logic        alu_carry,
    input  wire logic        alu_half_carry,
    input  wire logic        repeat_active,
    input  wire logic        loop_running,
    input  wire logic [2:0]  loop_nest_depth,
    input  wire logic        first_acc_overflow,
    input  wire logic        second_acc_overflow,
    input  wire logic        first_acc_clipped,
    input  wire logic        second_acc_clipped,
    input  wire logic        frame_create_instr,
    input  wire logic        frame_delete_instr,
    input  wire logic        call_instr,
    input  wire logic        exception_take,
    input  wire logic [7:0]  pc_top_byte,
    output logic      [15:0] exception_stack_word,
    output logic      [3:0]  priority_level,
    output logic             user_irq_disabled,
    output logic      [1:0]  multiply_sign_select,
    output logic             early_loop_exit,
    output logic             first_acc_clip_enable,
    output logic             second_acc_clip_enable,
    output logic             store_clip_enable,
    output logic             clip_width_select,
    output logic             frame_active_flag,
    output logic             round_select,
    output logic             integer_mode
);

    cscc_state_s st_reg;
    cscc_state_s st_next;
    logic        take;
    logic [15:0] wdata16;
    logic        wr_status;
    logic        wr_control;
    logic        wr_sysctl;
    logic [15:0] sr_tmp;

    ////////////////////////////////////////////////////////////////////////
    // Bus address phase: only NONSEQ/SEQ with hready high are taken.
    assign take = hsel && hready && htrans[1];
    assign wdata16 = hwdata[15:0];
    assign wr_status  = st_reg.dphase_reg && st_reg.dwrite_reg &&
                        (st_reg.daddr_reg == `CSCC_ADDR_STATUS);
    assign wr_control = st_reg.dphase_reg && st_reg.dwrite_reg &&
                        (st_reg.daddr_reg == `CSCC_ADDR_CONTROL);
    assign wr_sysctl  = st_reg.dphase_reg && st_reg.dwrite_reg &&
                        (st_reg.daddr_reg == `CSCC_ADDR_SYSCTL);

    // Zero-wait slave: every data phase completes at once with OKAY.
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = st_reg.rdata_reg;

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic for the whole bank.
    always_comb begin
        st_next = st_reg;
        sr_tmp  = st_reg.status_reg;
        st_next.exit_pulse_reg = 1'b0;
        st_next.dphase_reg = take;
        if (take) begin
            st_next.dwrite_reg = hwrite;
            st_next.daddr_reg  = haddr[`CSCC_ADDR_DECODE_W-1:0];
        end
        // Software write to the status word; hardware events below win.
        if (wr_status) begin
            sr_tmp = (wdata16 & ~`CSCC_SR_RO_MASK) |
                     (st_reg.status_reg & `CSCC_SR_RO_MASK);
            if (st_reg.nesting_disable_reg) begin
                sr_tmp[`CSCC_SR_IPL_LO +: 3] =
                    st_reg.status_reg[`CSCC_SR_IPL_LO +: 3];
            end
            if (!wdata16[`CSCC_SR_ANY_CLIP]) begin
                sr_tmp[`CSCC_SR_FIRST_CLIP]  = 1'b0;
                sr_tmp[`CSCC_SR_SECOND_CLIP] = 1'b0;
            end
            if (!wdata16[`CSCC_SR_ANY_OVF]) begin
                sr_tmp[`CSCC_SR_FIRST_OVF]  = 1'b0;
                sr_tmp[`CSCC_SR_SECOND_OVF] = 1'b0;
            end
        end
        // ALU flags from the affecting operation.
        if (alu_update) begin
            sr_tmp[`CSCC_SR_NEG]   = alu_neg;
            sr_tmp[`CSCC_SR_WRAP]  = alu_wrap;
            sr_tmp[`CSCC_SR_CARRY] = alu_carry;
            sr_tmp[`CSCC_SR_HALF]  = alu_half_carry;
            if (!alu_zero) begin
                sr_tmp[`CSCC_SR_ZERO] = 1'b0;
            end else begin
                sr_tmp[`CSCC_SR_ZERO] = 1'b1;
            end
        end
        sr_tmp[`CSCC_SR_REPEAT] = repeat_active;
        sr_tmp[`CSCC_SR_LOOP]   = loop_running;
        // Sticky DSP flags: a set arriving with a clear still wins.
        if (first_acc_overflow) begin
            sr_tmp[`CSCC_SR_FIRST_OVF] = 1'b1;
        end
        if (second_acc_overflow) begin
            sr_tmp[`CSCC_SR_SECOND_OVF] = 1'b1;
        end
        if (first_acc_clipped) begin
            sr_tmp[`CSCC_SR_FIRST_CLIP] = 1'b1;
        end
        if (second_acc_clipped) begin
            sr_tmp[`CSCC_SR_SECOND_CLIP] = 1'b1;
        end
        if (first_acc_overflow || second_acc_overflow) begin
            sr_tmp[`CSCC_SR_ANY_OVF] = 1'b1;
        end
        if (first_acc_clipped || second_acc_clipped) begin
            sr_tmp[`CSCC_SR_ANY_CLIP] = 1'b1;
        end
        st_next.status_reg = sr_tmp;
        // Control word write keeps read-only fields; exit bit pulses.
        if (wr_control) begin
            st_next.control_reg = (wdata16 & `CSCC_CC_WMASK) |
                (st_reg.control_reg & ~`CSCC_CC_WMASK);
            st_next.exit_pulse_reg = wdata16[`CSCC_CC_EXIT];
        end
        st_next.control_reg[`CSCC_CC_EXIT] = 1'b0;
        st_next.control_reg[`CSCC_CC_DEPTH_LO +: 3] = loop_nest_depth;
        st_next.control_reg[15:14] = 2'h0;
        // Frame flag: create sets; delete or call clears after stacking.
        if (frame_create_instr) begin
            st_next.control_reg[`CSCC_CC_FRAME] = 1'b1;
        end else if (frame_delete_instr || call_instr) begin
            st_next.control_reg[`CSCC_CC_FRAME] = 1'b0;
        end
        if (wr_sysctl) begin
            st_next.nesting_disable_reg = wdata16[`CSCC_SYS_NESTDIS];
        end
        // Exception stacking word captured from pre-update low byte.
        if (exception_take) begin
            st_next.exc_word_reg = {pc_top_byte, st_reg.status_reg[7:0]};
        end
        // Read data is prepared in the address phase.
        st_next.rdata_reg = 32'h0000_0000;
        if (take && !hwrite) begin
            unique case (haddr[`CSCC_ADDR_DECODE_W-1:0])
                `CSCC_ADDR_STATUS: begin
                    st_next.rdata_reg = {16'h0000, st_reg.status_reg};
                end
                `CSCC_ADDR_CONTROL: begin
                    st_next.rdata_reg = {16'h0000, st_reg.control_reg};
                end
                `CSCC_ADDR_EXCWORD: begin
                    st_next.rdata_reg = {16'h0000, st_reg.exc_word_reg};
                end
                `CSCC_ADDR_SYSCTL: begin
                    st_next.rdata_reg = {31'h0, st_reg.nesting_disable_reg};
                end
                default: begin
                    st_next.rdata_reg = 32'h0000_0000;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Single state register; reset gives documented power-on values.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_reg <= '{status_reg: `CSCC_SR_RESET,
                        control_reg: `CSCC_CC_RESET,
                        exc_word_reg: 16'h0000,
                        nesting_disable_reg: 1'b0,
                        dphase_reg: 1'b0,
                        dwrite_reg: 1'b0,
                        daddr_reg: 8'h00,
                        rdata_reg: 32'h0000_0000,
                        exit_pulse_reg: 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control outputs decoded straight from the stored words.
    assign priority_level = {st_reg.control_reg[`CSCC_CC_IPL_HI],
                             st_reg.status_reg[`CSCC_SR_IPL_LO +: 3]};
    assign user_irq_disabled = (priority_level >= `CSCC_USER_MAX_IPL);
    assign multiply_sign_select = st_reg.control_reg[`CSCC_CC_SIGN_LO +: 2];
    assign early_loop_exit        = st_reg.exit_pulse_reg;
    assign first_acc_clip_enable  = st_reg.control_reg[`CSCC_CC_FIRST_CLIP];
    assign second_acc_clip_enable = st_reg.control_reg[`CSCC_CC_SECOND_CLIP];
    assign store_clip_enable      = st_reg.control_reg[`CSCC_CC_STORE_CLIP];
    assign clip_width_select      = st_reg.control_reg[`CSCC_CC_CLIP_WIDTH];
    assign frame_active_flag      = st_reg.control_reg[`CSCC_CC_FRAME];
    assign round_select           = st_reg.control_reg[`CSCC_CC_ROUND];
    assign integer_mode           = st_reg.control_reg[`CSCC_CC_INT_MODE];
    assign exception_stack_word   = st_reg.exc_word_reg;

    ////////////////////////////////////////////////////////////////////////
    // Checks on the bank's behaviour.
    property p_ro_repeat;
        @(posedge hclk) disable iff (!hresetn)
        1'b1 |=> st_reg.status_reg[`CSCC_SR_REPEAT] == $past(repeat_active)
              && st_reg.status_reg[`CSCC_SR_LOOP] == $past(loop_running);
    endproperty
    a_ro_repeat: assert property (p_ro_repeat)
        else $error("repeat or loop flag not following hardware");

    property p_sticky;
        @(posedge hclk) disable iff (!hresetn)
        first_acc_overflow |=> st_reg.status_reg[`CSCC_SR_FIRST_OVF]
                            && st_reg.status_reg[`CSCC_SR_ANY_OVF];
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("overflow flag not set by event");

    property p_clip_clear;
        @(posedge hclk) disable iff (!hresetn)
        (wr_status && !wdata16[`CSCC_SR_ANY_CLIP] && !first_acc_clipped)
        |=> !st_reg.status_reg[`CSCC_SR_FIRST_CLIP];
    endproperty
    a_clip_clear: assert property (p_clip_clear)
        else $error("combined clip clear left first flag set");

    property p_ipl_lock;
        @(posedge hclk) disable iff (!hresetn)
        st_reg.nesting_disable_reg |=> $stable(st_reg.status_reg[7:5]);
    endproperty
    a_ipl_lock: assert property (p_ipl_lock)
        else $error("priority bits changed while locked");

    property p_top_prio;
        @(posedge hclk) disable iff (!hresetn)
        st_reg.control_reg[`CSCC_CC_IPL_HI] |-> user_irq_disabled;
    endproperty
    a_top_prio: assert property (p_top_prio)
        else $error("top priority bit did not disable interrupts");

    property p_exit_zero;
        @(posedge hclk) disable iff (!hresetn)
        1'b1 |-> !st_reg.control_reg[`CSCC_CC_EXIT];
    endproperty
    a_exit_zero: assert property (p_exit_zero)
        else $error("exit bit read back as one");

    property p_depth;
        @(posedge hclk) disable iff (!hresetn)
        1'b1 |=> st_reg.control_reg[10:8] == $past(loop_nest_depth);
    endproperty
    a_depth: assert property (p_depth)
        else $error("loop depth not reported");

    sequence s_create;
        frame_create_instr;
    endsequence
    property p_frame;
        @(posedge hclk) disable iff (!hresetn)
        s_create |=> frame_active_flag;
    endproperty
    a_frame: assert property (p_frame)
        else $error("frame flag not set by create");

    property p_exc;
        @(posedge hclk) disable iff (!hresetn)
        exception_take |=> exception_stack_word ==
            {$past(pc_top_byte), $past(st_reg.status_reg[7:0])};
    endproperty
    a_exc: assert property (p_exc)
        else $error("exception word wrong");

    // A same-cycle overflow event is excluded, since the set wins there.
    property p_ovf_clear;
        @(posedge hclk) disable iff (!hresetn)
        (wr_status && !wdata16[`CSCC_SR_ANY_OVF] && !first_acc_overflow)
        |=> !st_reg.status_reg[`CSCC_SR_FIRST_OVF];
    endproperty
    a_ovf_clear: assert property (p_ovf_clear)
        else $error("combined overflow clear left first flag set");

    property p_alu_flags;
        @(posedge hclk) disable iff (!hresetn)
        alu_update |=> st_reg.status_reg[`CSCC_SR_NEG] == $past(alu_neg)
                    && st_reg.status_reg[`CSCC_SR_WRAP] == $past(alu_wrap)
                    && st_reg.status_reg[`CSCC_SR_CARRY] == $past(alu_carry);
    endproperty
    a_alu_flags: assert property (p_alu_flags)
        else $error("ALU flags not loaded");

    property p_zero_clear;
        @(posedge hclk) disable iff (!hresetn)
        (alu_update && !alu_zero) |=> !st_reg.status_reg[`CSCC_SR_ZERO];
    endproperty
    a_zero_clear: assert property (p_zero_clear)
        else $error("zero flag kept after non-zero result");

    sequence s_unlink;
        (frame_delete_instr || call_instr) && !frame_create_instr;
    endsequence
    property p_frame_clear;
        @(posedge hclk) disable iff (!hresetn)
        s_unlink |=> !frame_active_flag;
    endproperty
    a_frame_clear: assert property (p_frame_clear)
        else $error("frame flag not cleared by delete or call");

    property p_exit_pulse;
        @(posedge hclk) disable iff (!hresetn)
        (wr_control && wdata16[`CSCC_CC_EXIT]) |=> early_loop_exit;
    endproperty
    a_exit_pulse: assert property (p_exit_pulse)
        else $error("loop exit strobe missing after write");

endmodule
`default_nettype wire

// ### verification/cscc_core_bench.sv
// Self-checking bench for the status and core control register bank.
`timescale 1ns/10ps
`default_nettype none
`include "cscc_params.svh"

module cscc_core_bench
    import cscc_pkg::*;
;
    logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans, multiply_sign_select;
    logic [2:0]  hsize, loop_nest_depth;
    logic        alu_update, alu_neg, alu_wrap, alu_zero, alu_carry;
    logic        alu_half_carry, repeat_active, loop_running;
    logic        first_acc_overflow, second_acc_overflow;
    logic        first_acc_clipped, second_acc_clipped;
    logic        frame_create_instr, frame_delete_instr, call_instr;
    logic        exception_take, user_irq_disabled, early_loop_exit;
    logic        first_acc_clip_enable, second_acc_clip_enable;
    logic        store_clip_enable, clip_width_select, frame_active_flag;
    logic        round_select, integer_mode;
    logic [7:0]  pc_top_byte;
    logic [15:0] exception_stack_word;
    logic [3:0]  priority_level;
    int          bad_count, cmp_count, exit_count;

    // The single slave drives the bus ready, so it is looped straight back.
    assign hready = hreadyout;

    cscc_core u_dut (.*);

    ////////////////////////////////////////////////////////////////////////
    // Clock, time-zero input values, reset and the pulse counter.
    initial begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end

    initial begin
        {hsel, hwrite, alu_update, alu_neg, alu_wrap, alu_zero} = '0;
        {alu_carry, alu_half_carry, repeat_active, loop_running} = '0;
        {first_acc_overflow, second_acc_overflow} = '0;
        {first_acc_clipped, second_acc_clipped, call_instr} = '0;
        {frame_create_instr, frame_delete_instr, exception_take} = '0;
        haddr = 32'h0000_0000;
        hwdata = 32'h0000_0000;
        htrans = 2'b00;
        hsize = 3'b010;
        loop_nest_depth = 3'h0;
        pc_top_byte = 8'h00;
        hresetn = 1'b0;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
    end

    // Counts every cycle the loop-exit strobe is high, to prove one pulse.
    always @(posedge hclk) begin
        if (early_loop_exit === 1'b1) begin
            exit_count <= exit_count + 1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus cycles and comparison.
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Address phase held until ready, then data phase held until ready.
    task automatic bus(input logic [7:0] a, input logic wr,
                       input logic [15:0] d);
        hsel <= 1'b1;
        haddr <= {24'h00_0000, a};
        htrans <= 2'b10;
        hwrite <= wr;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {16'h0000, d};
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        bus(a, 1'b1, d);
        @(posedge hclk); // Let the written state reach the outputs first.
    endtask

    task automatic rdchk(input string what, input logic [7:0] a,
                         input logic [15:0] exp);
        bus(a, 1'b0, 16'h0000);
        chk(what, {16'h0000, exp}, rd);
        chk("ready okay", 32'h2, {30'h0, hreadyout, hresp});
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Scenarios.
    task automatic t_reset_and_map();
        rdchk("status reset", `CSCC_ADDR_STATUS, 16'h0000);
        rdchk("control reset", `CSCC_ADDR_CONTROL, 16'h0020);
        chk("store clip", 32'h1, {31'h0, store_clip_enable});
        wr(8'h10, 16'hFFFF);
        rdchk("unmapped", 8'h10, 16'h0000);
        rdchk("status kept", `CSCC_ADDR_STATUS, 16'h0000);
    endtask

    // Sticky flags survive idle inputs; clearing a combined flag clears both.
    task automatic t_sticky();
        first_acc_overflow <= 1'b1;
        second_acc_clipped <= 1'b1;
        first_acc_clipped <= 1'b1;
        @(posedge hclk);
        {first_acc_overflow, first_acc_clipped, second_acc_clipped} <= '0;
        repeat (4) @(posedge hclk);
        rdchk("sticky set", `CSCC_ADDR_STATUS, 16'hBC00);
        wr(`CSCC_ADDR_STATUS, 16'hB800);
        rdchk("clip combined clear", `CSCC_ADDR_STATUS, 16'h8800);
        second_acc_overflow <= 1'b1;
        @(posedge hclk);
        second_acc_overflow <= 1'b0;
        wr(`CSCC_ADDR_STATUS, 16'hC000);
        rdchk("ovf combined clear", `CSCC_ADDR_STATUS, 16'h0000);
    endtask

    task automatic t_readonly_flags();
        wr(`CSCC_ADDR_STATUS, 16'h0210);
        rdchk("ro flags write", `CSCC_ADDR_STATUS, 16'h0000);
        repeat_active <= 1'b1;
        loop_running <= 1'b1;
        loop_nest_depth <= 3'h5;
        repeat (2) @(posedge hclk);
        rdchk("ro flags live", `CSCC_ADDR_STATUS, 16'h0210);
        wr(`CSCC_ADDR_CONTROL, 16'h0724);
        rdchk("depth", `CSCC_ADDR_CONTROL, 16'h0520);
        {repeat_active, loop_running} <= 2'b00;
        loop_nest_depth <= 3'h7;
        repeat (2) @(posedge hclk);
        rdchk("depth max", `CSCC_ADDR_CONTROL, 16'h0720);
    endtask

    task automatic t_priority();
        wr(`CSCC_ADDR_STATUS, 16'h00E0);
        chk("level 7", 32'h7, {28'h0, priority_level});
        chk("irq off 7", 32'h1, {31'h0, user_irq_disabled});
        wr(`CSCC_ADDR_STATUS, 16'h00C0);
        chk("level 6", 32'h6, {28'h0, priority_level});
        chk("irq on 6", 32'h0, {31'h0, user_irq_disabled});
        wr(`CSCC_ADDR_CONTROL, 16'h0028);
        chk("level 14", 32'hE, {28'h0, priority_level});
        chk("irq off hi", 32'h1, {31'h0, user_irq_disabled});
        wr(`CSCC_ADDR_CONTROL, 16'h0020);
        wr(`CSCC_ADDR_SYSCTL, 16'h0001);
        wr(`CSCC_ADDR_STATUS, 16'h0000);
        rdchk("ipl locked", `CSCC_ADDR_STATUS, 16'h00C0);
        wr(`CSCC_ADDR_SYSCTL, 16'h0000);
        wr(`CSCC_ADDR_STATUS, 16'h0000);
        rdchk("ipl free", `CSCC_ADDR_STATUS, 16'h0000);
    endtask

    task automatic t_alu();
        {alu_neg, alu_wrap, alu_zero, alu_carry, alu_half_carry} <= 5'b11011;
        alu_update <= 1'b1;
        @(posedge hclk);
        alu_update <= 1'b0;
        rdchk("alu flags", `CSCC_ADDR_STATUS, 16'h010D);
        {alu_neg, alu_wrap, alu_zero, alu_carry, alu_half_carry} <= 5'b00100;
        alu_update <= 1'b1;
        @(posedge hclk);
        alu_update <= 1'b0;
        rdchk("alu zero", `CSCC_ADDR_STATUS, 16'h0002);
        wr(`CSCC_ADDR_STATUS, 16'h0100);
        rdchk("half carry rw", `CSCC_ADDR_STATUS, 16'h0100);
    endtask

    // Each sign mode once, alternating all mode bits on and off.
    task automatic t_control();
        logic [15:0] d;
        int          n0;
        for (int i = 0; i < 4; i++) begin
            d = {2'b00, i[1:0], 12'h000} | (i[0] ? 16'h00F3 : 16'h0000);
            wr(`CSCC_ADDR_CONTROL, d);
            rdchk("control rw", `CSCC_ADDR_CONTROL, d | 16'h0700);
            chk("sign", {30'h0, i[1:0]}, {30'h0, multiply_sign_select});
            chk("mode bits", {26'h0, {6{i[0]}}},
                {26'h0, first_acc_clip_enable, second_acc_clip_enable,
                 store_clip_enable, clip_width_select, round_select,
                 integer_mode});
        end
        n0 = exit_count;
        wr(`CSCC_ADDR_CONTROL, 16'h0800);
        wr(`CSCC_ADDR_CONTROL, 16'h0000);
        repeat (3) @(posedge hclk);
        chk("exit pulses", 32'h1, exit_count - n0);
        rdchk("exit reads 0", `CSCC_ADDR_CONTROL, 16'h0700);
    endtask

    task automatic t_frame();
        frame_create_instr <= 1'b1;
        @(posedge hclk);
        frame_create_instr <= 1'b0;
        rdchk("frame set", `CSCC_ADDR_CONTROL, 16'h0704);
        call_instr <= 1'b1;
        @(posedge hclk);
        call_instr <= 1'b0;
        repeat (2) @(posedge hclk);
        chk("frame call", 32'h0, {31'h0, frame_active_flag});
        frame_create_instr <= 1'b1;
        @(posedge hclk);
        frame_create_instr <= 1'b0;
        frame_delete_instr <= 1'b1;
        @(posedge hclk);
        frame_delete_instr <= 1'b0;
        repeat (2) @(posedge hclk);
        chk("frame delete", 32'h0, {31'h0, frame_active_flag});
    endtask

    task automatic t_exception();
        wr(`CSCC_ADDR_STATUS, 16'h01A5);
        pc_top_byte <= 8'h3C;
        exception_take <= 1'b1;
        @(posedge hclk);
        exception_take <= 1'b0;
        repeat (2) @(posedge hclk);
        chk("stack word", 32'h3CA5, {16'h0, exception_stack_word});
        rdchk("stack word reg", `CSCC_ADDR_EXCWORD, 16'h3CA5);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Verdict, watchdog and main sequence.
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // The whole run needs well under a thousand cycles; this cuts a hang.
    initial begin
        repeat (20000) @(posedge hclk);
        bad_count++;
        final_report();
    end

    initial begin
        bad_count = 0;
        cmp_count = 0;
        wait (hresetn === 1'b1);
        @(posedge hclk);
        t_reset_and_map();
        t_sticky();
        t_readonly_flags();
        t_priority();
        t_alu();
        t_control();
        t_frame();
        t_exception();
        final_report();
    end
endmodule

`default_nettype wire
